// ### rtl/fvrp_pkg.sv
// Purpose: Shared constants for the flash command sequencer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Command codes, register offsets, field positions, reset values.
`default_nettype none
package fvrp_pkg;
  localparam logic [7:0] FVRP_CMD_ERASE_VERIFY = 8'h03;
  localparam logic [7:0] FVRP_CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] FVRP_CMD_PROGRAM = 8'h06;
  localparam logic [2:0] FVRP_IX_EV = 3'h2;
  localparam logic [2:0] FVRP_IX_RO = 3'h1;
  localparam logic [2:0] FVRP_IX_PG1 = 3'h3;
  localparam logic [2:0] FVRP_IX_PG2 = 3'h5;
  localparam logic [15:0] FVRP_PHRASE_MAX = 16'h0007;
  localparam int FVRP_ONCE_BYTES = 64;
  localparam int FVRP_PHRASES = 8;
  localparam int FVRP_WORDS = 6;
  localparam logic [7:0] FVRP_OFS_STATUS = 8'h00;
  localparam logic [7:0] FVRP_OFS_INDEX = 8'h04;
  localparam logic [7:0] FVRP_OFS_OBJECT = 8'h08;
  localparam logic [7:0] FVRP_OFS_MODE = 8'h0C;
  localparam logic [7:0] FVRP_OFS_PROT_LO = 8'h10;
  localparam logic [7:0] FVRP_OFS_PROT_HI = 8'h14;
  localparam int FVRP_BIT_COMPLETE = 7;
  localparam int FVRP_BIT_ACCESS_ERR = 5;
  localparam int FVRP_BIT_PVIOL = 4;
  localparam int FVRP_BIT_PROT_EN = 24;
  localparam logic [2:0] FVRP_MODE_RESET = 3'h7;
  localparam logic [24:0] FVRP_PROT_RESET = 25'h000_0000;
  localparam logic [31:0] FVRP_ERASED = 32'hFFFF_FFFF;
  typedef enum logic [4:0] {
    FVRP_ST_IDLE = 5'b00001,
    FVRP_ST_EV = 5'b00010,
    FVRP_ST_RO = 5'b00100,
    FVRP_ST_PW = 5'b01000,
    FVRP_ST_PV = 5'b10000
  } fvrp_state_t;
endpackage : fvrp_pkg
`default_nettype wire

// ### rtl/fvrp_sequencer.sv
// Purpose: Flash command sequencer for erase-verify section, read-once
//   and program-longword commands, with an APB register file.
// Assumes: Flash array behind a request/acknowledge port outside.
// Notes: Register bus answers with no wait states.
`default_nettype none
module fvrp_sequencer #(
  parameter logic [23:0] FLASH_SIZE = 24'h00_8000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_info,
  output logic [23:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_err,
  input wire logic mem_uncorr,
  output logic flash_read_invalid,
  output logic busy
);
  import fvrp_pkg::*;

  fvrp_state_t state_reg;
  logic [15:0] obj_reg [FVRP_WORDS];
  logic [2:0] index_reg;
  logic [2:0] mode_reg;
  logic [24:0] prot_lo_reg;
  logic [24:0] prot_hi_reg;
  logic complete_reg;
  logic access_err_reg;
  logic pviol_reg;
  logic [1:0] verify_reg;
  logic [15:0] count_reg;
  logic [23:0] addr_reg;
  logic pair_reg;
  logic pair_last_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  logic setup;
  logic wr_now;
  logic [7:0] ofs;
  logic mapped;
  logic launch;
  logic [7:0] code;
  logic [23:0] gaddr;
  logic [24:0] span;
  logic [24:0] end_addr;
  logic addr_bad;
  logic range_bad;
  logic align_bad;
  logic prot_hit;
  logic launch_err;
  logic go_ev;
  logic go_ro;
  logic go_pg;
  logic beat;
  logic [1:0] beat_vfy;
  logic [31:0] lw_data;
  logic last_beat;

  assign setup = psel && !penable;
  assign wr_now = psel && penable && pwrite;
  assign ofs = paddr[7:0];
  assign mapped = (paddr[31:8] == 24'h00_0000) &&
    (ofs == FVRP_OFS_STATUS || ofs == FVRP_OFS_INDEX ||
     ofs == FVRP_OFS_OBJECT || ofs == FVRP_OFS_MODE ||
     ofs == FVRP_OFS_PROT_LO || ofs == FVRP_OFS_PROT_HI);
  assign pready = 1'b1;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // A launch is a write of one to the complete flag while it is set and
  // no earlier error is pending.
  assign launch = wr_now && ofs == FVRP_OFS_STATUS &&
    pwdata[FVRP_BIT_COMPLETE] && complete_reg && !access_err_reg &&
    !pviol_reg;

  assign code = obj_reg[0][15:8];
  assign gaddr = {obj_reg[0][7:0], obj_reg[1]};

  always_comb
  begin
    span = 25'h000_0000;
    if (code == FVRP_CMD_ERASE_VERIFY)
    begin
      span = {7'h00, obj_reg[2], 2'b00};
    end
    else if (index_reg == FVRP_IX_PG2)
    begin
      span = 25'h000_0008;
    end
    else
    begin
      span = 25'h000_0004;
    end
  end

  assign end_addr = {1'b0, gaddr} + span;
  assign addr_bad = gaddr >= FLASH_SIZE;
  assign range_bad = end_addr > {1'b0, FLASH_SIZE};
  assign align_bad = gaddr[1:0] != 2'b00;
  assign prot_hit = prot_lo_reg[FVRP_BIT_PROT_EN] &&
    gaddr >= prot_lo_reg[23:0] && gaddr <= prot_hi_reg[23:0];

  always_comb
  begin
    launch_err = 1'b1;
    case (code)
      FVRP_CMD_ERASE_VERIFY:
      begin
        launch_err = index_reg != FVRP_IX_EV ||
          !mode_reg[0] || addr_bad || align_bad || range_bad;
      end
      FVRP_CMD_READ_ONCE:
      begin
        launch_err = index_reg != FVRP_IX_RO ||
          !mode_reg[1] || obj_reg[1] > FVRP_PHRASE_MAX;
      end
      FVRP_CMD_PROGRAM:
      begin
        launch_err = (index_reg != FVRP_IX_PG1 &&
          index_reg != FVRP_IX_PG2) || !mode_reg[2] ||
          addr_bad || align_bad || range_bad;
      end
      default:
      begin
        launch_err = 1'b1;
      end
    endcase
  end

  assign go_ev = launch && !launch_err && code == FVRP_CMD_ERASE_VERIFY;
  assign go_ro = launch && !launch_err && code == FVRP_CMD_READ_ONCE;
  assign go_pg = launch && !launch_err && code == FVRP_CMD_PROGRAM &&
    !prot_hit;

  assign beat = mem_req && mem_ack;
  assign lw_data = pair_reg ? {obj_reg[4], obj_reg[5]} :
    {obj_reg[2], obj_reg[3]};

  always_comb
  begin
    beat_vfy = 2'b00;
    if (mem_err)
    begin
      beat_vfy[1] = 1'b1;
    end
    if (mem_uncorr)
    begin
      beat_vfy[0] = 1'b1;
    end
    if (state_reg == FVRP_ST_EV && mem_rdata != FVRP_ERASED)
    begin
      beat_vfy = 2'b11;
    end
    if (state_reg == FVRP_ST_PV && mem_rdata != lw_data)
    begin
      beat_vfy = 2'b11;
    end
  end

  always_comb
  begin
    last_beat = 1'b0;
    case (state_reg)
      FVRP_ST_EV:
      begin
        last_beat = count_reg == 16'h0001;
      end
      FVRP_ST_RO, FVRP_ST_PV:
      begin
        last_beat = pair_reg == pair_last_reg;
      end
      default:
      begin
        last_beat = 1'b0;
      end
    endcase
  end

  // Sequencer walks the addressed longwords one beat per acknowledge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= FVRP_ST_IDLE;
      count_reg <= 16'h0000;
      addr_reg <= 24'h00_0000;
      pair_reg <= 1'b0;
      pair_last_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        FVRP_ST_IDLE:
        begin
          pair_reg <= 1'b0;
          if (go_ev)
          begin
            state_reg <= (obj_reg[2] == 16'h0000) ? FVRP_ST_IDLE :
              FVRP_ST_EV;
            count_reg <= obj_reg[2];
            addr_reg <= gaddr;
          end
          else if (go_ro)
          begin
            state_reg <= FVRP_ST_RO;
            pair_last_reg <= 1'b1;
            addr_reg <= {15'h0000, obj_reg[1][5:0], 3'b000};
          end
          else if (go_pg)
          begin
            state_reg <= FVRP_ST_PW;
            pair_last_reg <= index_reg == FVRP_IX_PG2;
            addr_reg <= gaddr;
          end
        end
        FVRP_ST_EV:
        begin
          if (beat)
          begin
            count_reg <= count_reg - 16'h0001;
            addr_reg <= addr_reg + 24'h00_0004;
            if (last_beat)
            begin
              state_reg <= FVRP_ST_IDLE;
            end
          end
        end
        FVRP_ST_RO:
        begin
          if (beat)
          begin
            addr_reg <= addr_reg + 24'h00_0004;
            pair_reg <= 1'b1;
            if (last_beat)
            begin
              state_reg <= FVRP_ST_IDLE;
            end
          end
        end
        FVRP_ST_PW:
        begin
          if (beat)
          begin
            if (pair_reg == pair_last_reg)
            begin
              state_reg <= FVRP_ST_PV;
              pair_reg <= 1'b0;
              addr_reg <= gaddr;
            end
            else
            begin
              pair_reg <= 1'b1;
              addr_reg <= addr_reg + 24'h00_0004;
            end
          end
        end
        FVRP_ST_PV:
        begin
          if (beat)
          begin
            pair_reg <= 1'b1;
            addr_reg <= addr_reg + 24'h00_0004;
            if (last_beat)
            begin
              state_reg <= FVRP_ST_IDLE;
            end
          end
        end
        default:
        begin
          state_reg <= FVRP_ST_IDLE;
        end
      endcase
    end
  end

  assign busy = state_reg != FVRP_ST_IDLE;
  assign flash_read_invalid = state_reg == FVRP_ST_RO;

  // Memory port outputs come straight from flip-flops.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_info <= 1'b0;
      mem_addr <= 24'h00_0000;
      mem_wdata <= 32'h0000_0000;
    end
    else
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_info <= 1'b0;
      mem_addr <= addr_reg;
      mem_wdata <= lw_data;
      case (state_reg)
        FVRP_ST_EV, FVRP_ST_PV:
        begin
          mem_req <= !(beat && last_beat);
        end
        FVRP_ST_RO:
        begin
          mem_req <= !(beat && last_beat);
          mem_info <= 1'b1;
        end
        FVRP_ST_PW:
        begin
          mem_req <= !(beat && pair_reg == pair_last_reg);
          mem_we <= 1'b1;
        end
        default:
        begin
          mem_req <= 1'b0;
        end
      endcase
      if (beat)
      begin
        mem_req <= 1'b0;
      end
    end
  end

  // Status flags: hardware sets win over software clears.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      complete_reg <= 1'b1;
      access_err_reg <= 1'b0;
      pviol_reg <= 1'b0;
      verify_reg <= 2'b00;
    end
    else
    begin
      if (wr_now && ofs == FVRP_OFS_STATUS)
      begin
        if (pwdata[FVRP_BIT_ACCESS_ERR])
        begin
          access_err_reg <= 1'b0;
        end
        if (pwdata[FVRP_BIT_PVIOL])
        begin
          pviol_reg <= 1'b0;
        end
      end
      if (launch)
      begin
        verify_reg <= 2'b00;
        if (launch_err)
        begin
          access_err_reg <= 1'b1;
        end
        else if (code == FVRP_CMD_PROGRAM && prot_hit)
        begin
          pviol_reg <= 1'b1;
        end
        else if (code == FVRP_CMD_ERASE_VERIFY && obj_reg[2] == 16'h0000)
        begin
          complete_reg <= 1'b1;
        end
        else
        begin
          complete_reg <= 1'b0;
        end
      end
      if (beat && state_reg != FVRP_ST_PW)
      begin
        verify_reg <= verify_reg | beat_vfy;
      end
      if (beat && last_beat)
      begin
        complete_reg <= 1'b1;
      end
    end
  end

  // Command object: software loads while idle, read-once fills words 2-5.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      index_reg <= 3'h0;
      for (int i = 0; i < FVRP_WORDS; i++)
      begin
        obj_reg[i] <= 16'h0000;
      end
    end
    else
    begin
      if (wr_now && complete_reg && ofs == FVRP_OFS_INDEX)
      begin
        index_reg <= pwdata[2:0];
      end
      if (wr_now && complete_reg && ofs == FVRP_OFS_OBJECT &&
          index_reg < 3'(FVRP_WORDS))
      begin
        obj_reg[index_reg] <= pwdata[15:0];
      end
      if (beat && state_reg == FVRP_ST_RO)
      begin
        obj_reg[{1'b0, pair_reg, 1'b0} + 3'h2] <= mem_rdata[31:16];
        obj_reg[{1'b0, pair_reg, 1'b0} + 3'h3] <= mem_rdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_reg <= FVRP_MODE_RESET;
      prot_lo_reg <= FVRP_PROT_RESET;
      prot_hi_reg <= FVRP_PROT_RESET;
    end
    else if (wr_now && complete_reg)
    begin
      if (ofs == FVRP_OFS_MODE)
      begin
        mode_reg <= pwdata[2:0];
      end
      if (ofs == FVRP_OFS_PROT_LO)
      begin
        prot_lo_reg <= pwdata[24:0];
      end
      if (ofs == FVRP_OFS_PROT_HI)
      begin
        prot_hi_reg <= {1'b0, pwdata[23:0]};
      end
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_reg <= !mapped;
      prdata_reg <= 32'h0000_0000;
      case (ofs)
        FVRP_OFS_STATUS:
        begin
          prdata_reg[FVRP_BIT_COMPLETE] <= complete_reg;
          prdata_reg[FVRP_BIT_ACCESS_ERR] <= access_err_reg;
          prdata_reg[FVRP_BIT_PVIOL] <= pviol_reg;
          prdata_reg[1:0] <= verify_reg;
        end
        FVRP_OFS_INDEX:
        begin
          prdata_reg[2:0] <= index_reg;
        end
        FVRP_OFS_OBJECT:
        begin
          if (index_reg < 3'(FVRP_WORDS))
          begin
            prdata_reg[15:0] <= obj_reg[index_reg];
          end
        end
        FVRP_OFS_MODE:
        begin
          prdata_reg[2:0] <= mode_reg;
        end
        FVRP_OFS_PROT_LO:
        begin
          prdata_reg[24:0] <= prot_lo_reg;
        end
        FVRP_OFS_PROT_HI:
        begin
          prdata_reg[24:0] <= prot_hi_reg;
        end
        default:
        begin
          prdata_reg <= 32'h0000_0000;
        end
      endcase
      if (!mapped)
      begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end
endmodule : fvrp_sequencer
`default_nettype wire

// ### bench/fvrp_seq_assertions.sv
// Purpose: Port-level checks of the flash command sequencer.
// Assumes: Bound to fvrp_sequencer with its FLASH_SIZE.
// Notes: Covers the APB error answer and the flash access port.
`default_nettype none
module fvrp_seq_assertions #(
  parameter logic [23:0] FLASH_SIZE = 24'h00_8000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_info,
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_err,
  input wire logic mem_uncorr,
  input wire logic flash_read_invalid,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_unmapped_err: assert property
    (psel && penable && paddr[31:8] != 0 |-> pslverr)
    else $error("unmapped access without slave error");
  chk_req_hold: assert property
    (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("flash request changed before acknowledge");
  chk_req_drop: assert property
    (mem_req && mem_ack |=> !mem_req)
    else $error("flash request held after acknowledge");
  chk_idle_quiet: assert property
    (!busy |-> !mem_req)
    else $error("flash request while idle");
  chk_info_read: assert property
    (mem_req && mem_info |-> !mem_we && flash_read_invalid)
    else $error("info access outside read-once");
  chk_info_select: assert property
    (mem_req && flash_read_invalid |-> mem_info)
    else $error("read-once access outside info field");
  chk_invalid_busy: assert property
    (flash_read_invalid |-> busy)
    else $error("read invalid flag while idle");
  chk_addr_align: assert property
    (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("misaligned flash access");
  chk_addr_range: assert property
    (mem_req && !mem_info |-> mem_addr < FLASH_SIZE)
    else $error("flash access beyond block end");
  chk_busy_bound: assert property
    ($rose(busy) |-> ##[1:200] !busy)
    else $error("command did not complete in time");
endmodule // fvrp_seq_assertions

bind fvrp_sequencer fvrp_seq_assertions #(.FLASH_SIZE(FLASH_SIZE))
  fvrp_seq_assertions_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_info(mem_info), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
  .mem_err(mem_err), .mem_uncorr(mem_uncorr),
  .flash_read_invalid(flash_read_invalid), .busy(busy));
`default_nettype wire

// ### bench/fvrp_sequencer_tb.sv
// Purpose: Self-checking bench for the flash command sequencer.
// Assumes: Zero-wait APB; bench answers the flash port itself.
// Notes: A four-word flash image is indexed by address bits 3:2.
`default_nettype none
module fvrp_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fvrp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, mem_wdata, mem_rdata, q;
  logic pready, pslverr, mem_req, mem_we, mem_info, busy, inv, se, saw_inv;
  logic [23:0] mem_addr;
  logic mem_ack = 1'b0;
  logic mem_err, mem_uncorr;
  logic [31:0] store [4];
  logic [31:0] flip = '0;
  logic [1:0] inj = '0;
  logic [15:0] ws [6];
  int err_total = 0;
  int num_checks = 0;

  always #5 pclk = ~pclk;

  fvrp_sequencer #(.FLASH_SIZE(24'h00_8000)) fvrp_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_info(mem_info), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_err(mem_err), .mem_uncorr(mem_uncorr),
    .flash_read_invalid(inv), .busy(busy));

  // Read data is scrambled outside an acknowledge so stale values fail.
  always @(posedge pclk)
  begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && mem_ack && mem_we)
      store[mem_addr[3:2]] <= mem_wdata;
  end
  assign mem_rdata = mem_ack ? store[mem_addr[3:2]] ^ flip :
    ~store[mem_addr[3:2]];
  assign mem_err = mem_ack & inj[1];
  assign mem_uncorr = mem_ack & inj[0];

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      err_total++;
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      err_total++;
      summarize();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {24'h00_0000, a}, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, {24'h00_0000, a}, '0);
    chk(q, e);
  endtask

  // Loads n words, sets the launch index, launches and reads status.
  task automatic run(input int n, input logic [2:0] ix,
    input logic [31:0] st);
    int k;
    for (int i = 0; i < n; i++)
    begin
      wr(FVRP_OFS_INDEX, 32'(i));
      wr(FVRP_OFS_OBJECT, {16'h0000, ws[i]});
    end
    wr(FVRP_OFS_INDEX, {29'h0000_0000, ix});
    wr(FVRP_OFS_STATUS, 32'h0000_0080);
    saw_inv = 1'b0;
    k = 0;
    @(negedge pclk);
    while (busy !== 1'b0 && k < 500)
    begin
      saw_inv |= inv;
      @(negedge pclk);
      k++;
    end
    if (k >= 500)
    begin
      err_total++;
      summarize();
    end
    @(posedge pclk);
    rd(FVRP_OFS_STATUS, st);
  endtask

  task automatic clr();
    wr(FVRP_OFS_STATUS, 32'h0000_0030);
    rd(FVRP_OFS_STATUS, 32'h0000_0080);
  endtask

  task automatic t_reset();
    rd(FVRP_OFS_STATUS, 32'h0000_0080);
    apb(1'b0, 32'h0000_0100, '0);
    chk({31'h0000_0000, se}, 32'h0000_0001);
    wr(FVRP_OFS_INDEX, 32'h0000_0001);
    wr(FVRP_OFS_OBJECT, 32'h0000_A5C3);
    wr(FVRP_OFS_INDEX, 32'h0000_0000);
    rd(FVRP_OFS_OBJECT, 32'h0000_0000);
    wr(FVRP_OFS_INDEX, 32'h0000_0001);
    rd(FVRP_OFS_OBJECT, 32'h0000_A5C3);
    $display("test reset done");
  endtask

  task automatic t_ev();
    ws[0] = 16'h0300;
    ws[1] = 16'h0100;
    ws[2] = 16'h0002;
    run(3, FVRP_IX_EV, 32'h0000_0080);
    flip <= 32'h0000_0001;
    run(3, FVRP_IX_EV, 32'h0000_0083);
    flip <= '0;
    for (int i = 2; i < 4; i++)
    begin
      inj <= i[1:0];
      run(3, FVRP_IX_EV, 32'h0000_0080 | 32'(i));
    end
    inj <= '0;
    $display("test erase verify done");
  endtask

  task automatic t_ev_bad();
    logic [15:0] a0 [5] = '{16'h0300, 16'h0300, 16'h0300, 16'h0301,
      16'h0300};
    logic [15:0] a1 [5] = '{16'h0100, 16'h0102, 16'h7FFC, 16'h0000,
      16'h0100};
    for (int i = 0; i < 5; i++)
    begin
      ws[0] = a0[i];
      ws[1] = a1[i];
      ws[2] = 16'h0002;
      if (i == 4)
        wr(FVRP_OFS_MODE, 32'h0000_0000);
      run(3, i == 0 ? FVRP_IX_RO : FVRP_IX_EV, 32'h0000_00A0);
      wr(FVRP_OFS_MODE, 32'h0000_0007);
      clr();
    end
    $display("test erase verify errors done");
  endtask

  task automatic t_ro();
    logic [15:0] e [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
    store[2] = 32'h1234_5678;
    store[3] = 32'h9ABC_DEF0;
    ws[0] = 16'h0400;
    ws[1] = 16'h0003;
    run(2, FVRP_IX_RO, 32'h0000_0080);
    chk({31'h0000_0000, saw_inv}, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
    begin
      wr(FVRP_OFS_INDEX, 32'(i + 2));
      rd(FVRP_OFS_OBJECT, {16'h0000, e[i]});
    end
    inj <= 2'b01;
    run(2, FVRP_IX_RO, 32'h0000_0081);
    inj <= '0;
    ws[1] = 16'h0008;
    run(2, FVRP_IX_RO, 32'h0000_00A0);
    clr();
    ws[1] = 16'h0003;
    run(2, FVRP_IX_EV, 32'h0000_00A0);
    clr();
    wr(FVRP_OFS_MODE, 32'h0000_0005);
    run(2, FVRP_IX_RO, 32'h0000_00A0);
    wr(FVRP_OFS_MODE, 32'h0000_0007);
    clr();
    store[2] = 32'hFFFF_FFFF;
    store[3] = 32'hFFFF_FFFF;
    $display("test read once done");
  endtask

  task automatic t_pg();
    ws = '{16'h0600, 16'h0200, 16'h1111, 16'h2222, 16'h3333, 16'h4444};
    run(6, FVRP_IX_PG2, 32'h0000_0080);
    chk(store[0], 32'h1111_2222);
    chk(store[1], 32'h3333_4444);
    ws[1] = 16'h0208;
    flip <= 32'h0000_0100;
    run(6, FVRP_IX_PG1, 32'h0000_0083);
    flip <= '0;
    run(6, 3'h4, 32'h0000_00A0);
    clr();
    ws[1] = 16'h0202;
    run(6, FVRP_IX_PG1, 32'h0000_00A0);
    clr();
    ws[1] = 16'h7FFC;
    run(6, FVRP_IX_PG2, 32'h0000_00A0);
    clr();
    ws[1] = 16'h0210;
    wr(FVRP_OFS_MODE, 32'h0000_0003);
    run(6, FVRP_IX_PG2, 32'h0000_00A0);
    wr(FVRP_OFS_MODE, 32'h0000_0007);
    clr();
    wr(FVRP_OFS_PROT_LO, 32'h0100_0210);
    wr(FVRP_OFS_PROT_HI, 32'h0000_0214);
    run(6, FVRP_IX_PG2, 32'h0000_0090);
    clr();
    $display("test program done");
  endtask

  initial
  begin
    for (int i = 0; i < 4; i++)
      store[i] = 32'hFFFF_FFFF;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_ev();
    t_ev_bad();
    t_ro();
    t_pg();
    summarize();
  end
endmodule // fvrp_sequencer_tb
`default_nettype wire
